/* File: mck_pkg.sv */
`default_nettype none
package mck_pkg;

  // byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_IENCLR = 5'h01;
  localparam logic [4:0] OFS_IENSET = 5'h02;
  localparam logic [4:0] OFS_IFLAG  = 5'h03;
  localparam logic [4:0] OFS_DIV    = 5'h05;
  localparam logic [4:0] OFS_RSV    = 5'h08;
  localparam logic [4:0] OFS_FAST   = 5'h10;
  localparam logic [4:0] OFS_BRA    = 5'h14;
  localparam logic [4:0] OFS_BRB    = 5'h18;
  localparam logic [4:0] OFS_BRC    = 5'h1c;

  // access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // clock-ready bit position in the enable and flag bytes
  localparam int RDY_BIT = 0;

  // implemented bits
  localparam logic [7:0]  CTRL_MASK = 8'h07;
  localparam logic [31:0] FAST_MASK = 32'h0000_10df;
  localparam logic [31:0] BRA_MASK  = 32'h0000_3fff;
  localparam logic [31:0] BRB_MASK  = 32'h0000_0017;
  localparam logic [31:0] BRC_MASK  = 32'h0000_1fff;

  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  DIV_RST  = 8'h01;
  localparam logic [31:0] FAST_RST = FAST_MASK;
  localparam logic [31:0] BRA_RST  = BRA_MASK;
  localparam logic [31:0] BRB_RST  = BRB_MASK;
  localparam logic [31:0] BRC_RST  = BRC_MASK;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic [1:0]  size;
    logic        wr;
    logic        rd;
    logic        nonsec;
  } mck_bus_req_type;

  typedef struct packed {
    logic [31:0] fast;
    logic [31:0] bra;
    logic [31:0] brb;
    logic [31:0] brc;
  } mck_gates_type;

  typedef struct packed {
    logic [7:0]    ctrl;
    logic [7:0]    div;
    mck_gates_type gates;
    logic          ien;
    logic          flag;
    logic          rdy_s1;
    logic          rdy_s2;
    logic          rdy_prev;
    logic [31:0]   rdata;
    logic          irq;
    logic          pac_err;
  } mck_state_type;

endpackage : mck_pkg
`default_nettype wire

/* File: mck_regs.sv */
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module mck_regs (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire mck_pkg::mck_bus_req_type bus,
  input  wire logic                     wr_protect,
  input  wire logic                     periph_secure,
  input  wire logic                     clk_ready_in,
  output logic [31:0]                   rdata,
  output logic                          pac_err,
  output logic                          irq,
  output logic [7:0]                    clock_source_select,
  output logic [7:0]                    processor_clock_divider,
  output mck_pkg::mck_gates_type        gates
);
  import mck_pkg::*;

  mck_state_type s_r;
  mck_state_type s_nxt;

  logic [3:0]  be;
  logic        deny;
  logic        wr_ok;
  logic        wr_prot_ok;
  logic        rdy_rise;
  logic [31:0] rd_word;

  // byte lanes of an access; a misaligned half falls to its aligned half
  function automatic logic [3:0] lanes(
    input logic [1:0] a,
    input logic [1:0] sz
  );
    logic [3:0] r;
    r = 4'h0;
    case (sz)
      SZ_BYTE: begin
        r[a] = 1'b1;
      end
      SZ_HALF: begin
        r = a[1] ? 4'hc : 4'h3;
      end
      SZ_WORD: begin
        r = 4'hf;
      end
      default: begin
        r = 4'h0;
      end
    endcase
    return r;
  endfunction : lanes

  function automatic logic [7:0] get_byte(
    input logic [31:0] d,
    input logic [1:0]  i
  );
    logic [31:0] t;
    t = d >> {i, 3'b000};
    return t[7:0];
  endfunction : get_byte

  // the written byte of lane i carries a one at the ready position
  function automatic logic ready_bit_written(
    input logic [31:0] d,
    input logic [1:0]  i
  );
    logic [7:0] b;
    b = get_byte(d, i);
    return b[RDY_BIT];
  endfunction : ready_bit_written

  // byte enables widened to a bit mask
  function automatic logic [31:0] lane_bits(
    input logic [3:0] en
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        r[i*8 +: 8] = 8'hff;
      end
    end
    return r;
  endfunction : lane_bits

  function automatic logic [31:0] put_byte(
    input logic [31:0] d,
    input logic [1:0]  i,
    input logic [7:0]  b
  );
    logic [31:0] t;
    t = d;
    t[{i, 3'b000} +: 8] = b;
    return t;
  endfunction : put_byte

  // merge written lanes, then drop unimplemented bits
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  en,
    input logic [31:0] msk
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r & msk;
  endfunction : merge

  function automatic logic hit(
    input logic [4:0] a,
    input logic [4:0] ofs
  );
    return a[4:2] == ofs[4:2];
  endfunction : hit

  always_comb begin
    s_nxt = s_r;
    be    = lanes(bus.addr[1:0], bus.size);
    // secure peripheral refuses non-secure masters
    deny       = periph_secure & bus.nonsec;
    wr_ok      = bus.wr & ~deny;
    wr_prot_ok = wr_ok & ~wr_protect;
    rd_word    = 32'h0000_0000;

    // ready input is asynchronous: two flops before the edge detector
    s_nxt.rdy_s1   = clk_ready_in;
    s_nxt.rdy_s2   = s_r.rdy_s1;
    s_nxt.rdy_prev = s_r.rdy_s2;
    rdy_rise       = s_r.rdy_s2 & ~s_r.rdy_prev;

    s_nxt.pac_err = (bus.wr | bus.rd) & deny;

    // control, enable set/clear: write protected
    if (wr_prot_ok && hit(bus.addr, OFS_CTRL)) begin
      if (be[OFS_CTRL[1:0]]) begin
        s_nxt.ctrl = get_byte(bus.wdata, OFS_CTRL[1:0]) & CTRL_MASK;
      end
      if (be[OFS_IENCLR[1:0]] && ready_bit_written(bus.wdata, OFS_IENCLR[1:0])) begin
        s_nxt.ien = 1'b0;
      end
      if (be[OFS_IENSET[1:0]] && ready_bit_written(bus.wdata, OFS_IENSET[1:0])) begin
        s_nxt.ien = 1'b1;
      end
    end

    // the flag register carries no write protection
    if (wr_ok && hit(bus.addr, OFS_IFLAG) && be[OFS_IFLAG[1:0]]) begin
      if (ready_bit_written(bus.wdata, OFS_IFLAG[1:0])) begin
        s_nxt.flag = 1'b0;
      end
    end
    // set after clear so a same-cycle event is not lost
    if (rdy_rise) begin
      s_nxt.flag = 1'b1;
    end

    if (wr_prot_ok && hit(bus.addr, OFS_DIV) && be[OFS_DIV[1:0]]) begin
      s_nxt.div = get_byte(bus.wdata, OFS_DIV[1:0]);
    end

    if (wr_prot_ok && hit(bus.addr, OFS_FAST)) begin
      s_nxt.gates.fast = merge(s_r.gates.fast, bus.wdata, be, FAST_MASK);
    end
    if (wr_prot_ok && hit(bus.addr, OFS_BRA)) begin
      s_nxt.gates.bra = merge(s_r.gates.bra, bus.wdata, be, BRA_MASK);
    end
    if (wr_prot_ok && hit(bus.addr, OFS_BRB)) begin
      s_nxt.gates.brb = merge(s_r.gates.brb, bus.wdata, be, BRB_MASK);
    end
    if (wr_prot_ok && hit(bus.addr, OFS_BRC)) begin
      s_nxt.gates.brc = merge(s_r.gates.brc, bus.wdata, be, BRC_MASK);
    end

    // read mux; unmapped and reserved words stay zero
    if (hit(bus.addr, OFS_CTRL)) begin
      rd_word = put_byte(rd_word, OFS_CTRL[1:0], s_r.ctrl);
      rd_word = put_byte(rd_word, OFS_IENCLR[1:0], {7'h00, s_r.ien});
      rd_word = put_byte(rd_word, OFS_IENSET[1:0], {7'h00, s_r.ien});
      rd_word = put_byte(rd_word, OFS_IFLAG[1:0], {7'h00, s_r.flag});
    end else if (hit(bus.addr, OFS_DIV)) begin
      rd_word = put_byte(rd_word, OFS_DIV[1:0], s_r.div);
    end else if (hit(bus.addr, OFS_FAST)) begin
      rd_word = s_r.gates.fast;
    end else if (hit(bus.addr, OFS_BRA)) begin
      rd_word = s_r.gates.bra;
    end else if (hit(bus.addr, OFS_BRB)) begin
      rd_word = s_r.gates.brb;
    end else if (hit(bus.addr, OFS_BRC)) begin
      rd_word = s_r.gates.brc;
    end

    // lanes outside the access read zero; data holds one cycle only
    s_nxt.rdata = 32'h0000_0000;
    if (bus.rd && !deny) begin
      for (int i = 0; i < 4; i++) begin
        if (be[i]) begin
          s_nxt.rdata[i*8 +: 8] = rd_word[i*8 +: 8];
        end
      end
    end

    s_nxt.irq = s_nxt.flag & s_nxt.ien;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r.ctrl       <= CTRL_RST;
      s_r.div        <= DIV_RST;
      s_r.gates.fast <= FAST_RST;
      s_r.gates.bra  <= BRA_RST;
      s_r.gates.brb  <= BRB_RST;
      s_r.gates.brc  <= BRC_RST;
      s_r.ien        <= 1'b0;
      s_r.flag       <= 1'b0;
      s_r.rdy_s1     <= 1'b0;
      s_r.rdy_s2     <= 1'b0;
      s_r.rdy_prev   <= 1'b0;
      s_r.rdata      <= 32'h0000_0000;
      s_r.irq        <= 1'b0;
      s_r.pac_err    <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata                   = s_r.rdata;
  assign pac_err                 = s_r.pac_err;
  assign irq                     = s_r.irq;
  assign clock_source_select     = s_r.ctrl;
  assign processor_clock_divider = s_r.div;
  assign gates                   = s_r.gates;

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_nonsec_read_zero: assert property (
    bus.rd && bus.nonsec && periph_secure |=> rdata == 32'h0000_0000
  ) else $error("non-secure read of secure bank returned data");

  a_nonsec_err_flag: assert property (
    (bus.rd || bus.wr) && bus.nonsec && periph_secure |=> pac_err
  ) else $error("refused access raised no error");

  a_open_no_err: assert property (
    !periph_secure |=> !pac_err
  ) else $error("error raised while bank is non-secure");

  a_protect_holds_fast: assert property (
    bus.wr && wr_protect && hit(bus.addr, OFS_FAST)
    |=> gates.fast == $past(gates.fast)
  ) else $error("protected gate mask was written");

  a_div_write_lands: assert property (
    bus.wr && !deny && !wr_protect && hit(bus.addr, OFS_DIV) && be[OFS_DIV[1:0]]
    |=> processor_clock_divider == get_byte($past(bus.wdata), OFS_DIV[1:0])
  ) else $error("divider write not stored");

  a_byte_keeps_lanes: assert property (
    bus.wr && bus.size == SZ_BYTE && bus.addr == OFS_FAST
    |=> gates.fast[31:8] == $past(gates.fast[31:8])
  ) else $error("byte write disturbed other lanes");

  a_ready_sets_flag: assert property (
    rdy_rise |=> s_r.flag ##1 irq == s_r.ien || !s_r.flag
  ) else $error("ready edge did not set flag");

  a_irq_follows: assert property (
    s_r.flag && s_r.ien |-> irq
  ) else $error("interrupt missing while flag enabled");

  a_reserved_reads: assert property (
    bus.rd && hit(bus.addr, OFS_RSV) |=> rdata == 32'h0000_0000
  ) else $error("reserved offset read nonzero");

  a_ctrl_write_lands: assert property (
    bus.wr && !deny && !wr_protect && hit(bus.addr, OFS_CTRL) && be[OFS_CTRL[1:0]]
    |=> clock_source_select == (get_byte($past(bus.wdata), OFS_CTRL[1:0]) & CTRL_MASK)
  ) else $error("control write not stored");

  a_enable_set_lands: assert property (
    bus.wr && !deny && !wr_protect && hit(bus.addr, OFS_IENSET)
    && be[OFS_IENSET[1:0]] && ready_bit_written(bus.wdata, OFS_IENSET[1:0])
    |=> s_r.ien
  ) else $error("enable-set write did not enable");

  a_enable_clear_lands: assert property (
    bus.wr && !deny && !wr_protect && hit(bus.addr, OFS_IENCLR)
    && be[OFS_IENCLR[1:0]] && ready_bit_written(bus.wdata, OFS_IENCLR[1:0])
    && !(be[OFS_IENSET[1:0]] && ready_bit_written(bus.wdata, OFS_IENSET[1:0]))
    |=> !s_r.ien
  ) else $error("enable-clear write did not disable");

  a_flag_clear_drops: assert property (
    bus.wr && !deny && hit(bus.addr, OFS_IFLAG) && be[OFS_IFLAG[1:0]]
    && ready_bit_written(bus.wdata, OFS_IFLAG[1:0]) && !rdy_rise
    |=> !s_r.flag && !irq
  ) else $error("flag clear did not drop the request");

  a_irq_holds: assert property (
    irq && !bus.wr
    |=> irq
  ) else $error("interrupt dropped with no write");

  a_protect_holds_regs: assert property (
    bus.wr && wr_protect
    |=> $stable(clock_source_select) && $stable(processor_clock_divider)
        && $stable(gates) && $stable(s_r.ien)
  ) else $error("protected register was written");

  a_refused_write_held: assert property (
    bus.wr && deny
    |=> $stable(clock_source_select) && $stable(processor_clock_divider)
        && $stable(gates) && $stable(s_r.ien)
  ) else $error("refused write changed a register");

  a_read_one_cycle: assert property (
    !bus.rd
    |=> rdata == 32'h0000_0000
  ) else $error("read data outside its cycle");

  a_err_one_cycle: assert property (
    !bus.wr && !bus.rd
    |=> !pac_err
  ) else $error("error raised with no access");

  a_lanes_read_zero: assert property (
    bus.rd
    |=> (rdata & ~lane_bits($past(be))) == 32'h0000_0000
  ) else $error("lane outside the access read nonzero");

  a_fast_word_read: assert property (
    bus.rd && !deny && bus.size == SZ_WORD && hit(bus.addr, OFS_FAST)
    |=> rdata == $past(gates.fast)
  ) else $error("fast bus mask read wrong");

  a_div_word_read: assert property (
    bus.rd && !deny && bus.size == SZ_WORD && hit(bus.addr, OFS_DIV)
    |=> rdata == {16'h0000, $past(processor_clock_divider), 8'h00}
  ) else $error("divider word read wrong");

  a_half_keeps_lanes: assert property (
    bus.wr && bus.size == SZ_HALF && hit(bus.addr, OFS_BRC) && !bus.addr[1]
    |=> gates.brc[31:16] == $past(gates.brc[31:16])
  ) else $error("half write disturbed the upper half");

  a_reserved_bits_zero: assert property (
    (clock_source_select & ~CTRL_MASK) == 8'h00
    && (gates & ~{FAST_MASK, BRA_MASK, BRB_MASK, BRC_MASK}) == 128'h0
  ) else $error("reserved bit reads nonzero");

  c_ready_irq: cover property (rdy_rise ##1 s_r.ien);
  c_refused: cover property (pac_err);
  c_half_write: cover property (bus.wr && bus.size == SZ_HALF);
  c_protected: cover property (bus.wr && wr_protect);
  c_flag_cleared: cover property (s_r.flag ##1 !s_r.flag);

endmodule : mck_regs
`default_nettype wire

/* File: mck_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import mck_pkg::*;
  logic            sys_clk = 1'b0;
  logic            rst = 1'b1;
  mck_bus_req_type bus = '0;
  logic            wr_protect = 1'b0;
  logic            periph_secure = 1'b0;
  logic            clk_ready_in = 1'b0;
  logic [31:0]     rdata;
  logic            pac_err;
  logic            irq;
  logic [7:0]      css;
  logic [7:0]      div;
  mck_gates_type   gates;
  int              err_total = 0;
  int              checked = 0;
  logic [4:0]      ofs [4] = '{OFS_FAST, OFS_BRA, OFS_BRB, OFS_BRC};
  logic [31:0]     msk [4] = '{FAST_MASK, BRA_MASK, BRB_MASK, BRC_MASK};

  mck_regs uut (
    .sys_clk                 (sys_clk),
    .rst                     (rst),
    .bus                     (bus),
    .wr_protect              (wr_protect),
    .periph_secure           (periph_secure),
    .clk_ready_in            (clk_ready_in),
    .rdata                   (rdata),
    .pac_err                 (pac_err),
    .irq                     (irq),
    .clock_source_select     (css),
    .processor_clock_divider (div),
    .gates                   (gates)
  );

  always #25 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // one bus cycle; returns one ns after the answer edge, where rdata stands
  task automatic acc(input logic w, input logic [4:0] a, input logic [1:0] s,
                     input logic [31:0] d, input logic ns);
    @(posedge sys_clk);
    bus.addr   <= a;
    bus.wdata  <= d;
    bus.size   <= s;
    bus.wr     <= w;
    bus.rd     <= !w;
    bus.nonsec <= ns;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    #1;
  endtask : acc

  // irq is registered behind a synchroniser, so allow a few edges
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("irq", {31'h0, e}, {31'h0, irq});
    if (irq !== e) end_of_test();
  endtask : wait_irq

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("div_rst", 32'h0000_0001, {24'h0, div});
    chk("css_rst", 32'h0000_0000, {24'h0, css});
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, ofs[i], SZ_WORD, 32'h0, 1'b0);
      chk("mask_rst", msk[i], rdata);
      acc(1'b1, ofs[i], SZ_WORD, 32'h0, 1'b0);
      chk("mask_clr", 32'h0, gates[32*(3-i) +: 32]);
      acc(1'b1, ofs[i], SZ_WORD, 32'hffff_ffff, 1'b0);
      acc(1'b0, ofs[i], SZ_WORD, 32'h0, 1'b0);
      chk("mask_set", msk[i], rdata);
    end
    acc(1'b1, 5'h14, SZ_BYTE, 32'h0000_0000, 1'b0);
    chk("bra_b0", 32'h0000_3f00, gates.bra);
    acc(1'b1, 5'h15, SZ_BYTE, 32'h0000_1200, 1'b0);
    chk("bra_b1", 32'h0000_1200, gates.bra);
    acc(1'b0, 5'h15, SZ_BYTE, 32'h0, 1'b0);
    chk("bra_rd_b1", 32'h0000_1200, rdata);
    acc(1'b1, 5'h1d, SZ_HALF, 32'h0000_0aa5, 1'b0);
    chk("brc_half", 32'h0000_0aa5, gates.brc);
    acc(1'b0, 5'h1e, SZ_HALF, 32'h0, 1'b0);
    chk("brc_hi_rd", 32'h0, rdata);
    acc(1'b1, OFS_CTRL, SZ_BYTE, 32'h0000_00ff, 1'b0);
    chk("css_wr", 32'h0000_0007, {24'h0, css});
    acc(1'b1, OFS_DIV, SZ_BYTE, 32'h0000_0800, 1'b0);
    chk("div_wr", 32'h0000_0008, {24'h0, div});
    acc(1'b1, 5'h04, SZ_BYTE, 32'h0000_00ff, 1'b0);
    acc(1'b0, 5'h04, SZ_WORD, 32'h0, 1'b0);
    chk("rsv_04", 32'h0000_0800, rdata);
    acc(1'b1, OFS_RSV, SZ_WORD, 32'hffff_ffff, 1'b0);
    acc(1'b0, OFS_RSV, SZ_WORD, 32'h0, 1'b0);
    chk("rsv_08", 32'h0, rdata);
    @(posedge sys_clk);
    wr_protect <= 1'b1;
    acc(1'b1, OFS_DIV, SZ_BYTE, 32'h0000_3300, 1'b0);
    chk("div_prot", 32'h0000_0008, {24'h0, div});
    acc(1'b1, OFS_BRB, SZ_WORD, 32'h0, 1'b0);
    chk("brb_prot", BRB_MASK, gates.brb);
    @(posedge sys_clk);
    wr_protect <= 1'b0;
    acc(1'b1, OFS_DIV, SZ_BYTE, 32'h0000_0200, 1'b1);
    chk("div_ns_open", 32'h0000_0002, {24'h0, div});
    chk("perr_open", 32'h0, {31'h0, pac_err});
    @(posedge sys_clk);
    periph_secure <= 1'b1;
    acc(1'b1, OFS_DIV, SZ_BYTE, 32'h0000_0500, 1'b1);
    chk("div_ns_sec", 32'h0000_0002, {24'h0, div});
    chk("perr_wr", 32'h1, {31'h0, pac_err});
    acc(1'b0, OFS_FAST, SZ_WORD, 32'h0, 1'b1);
    chk("rd_ns_sec", 32'h0, rdata);
    chk("perr_rd", 32'h1, {31'h0, pac_err});
    acc(1'b0, 5'h04, SZ_WORD, 32'h0, 1'b0);
    chk("rd_sec", 32'h0000_0200, rdata);
    chk("perr_sec", 32'h0, {31'h0, pac_err});
    acc(1'b1, OFS_IENSET, SZ_BYTE, 32'h0001_0000, 1'b0);
    acc(1'b0, OFS_CTRL, SZ_WORD, 32'h0, 1'b0);
    chk("word_00", 32'h0001_0107, rdata);
    wait_irq(1'b0);
    @(posedge sys_clk);
    clk_ready_in <= 1'b1;
    wait_irq(1'b1);
    acc(1'b0, OFS_IFLAG, SZ_BYTE, 32'h0, 1'b0);
    chk("flag_set", 32'h0100_0000, rdata);
    acc(1'b1, OFS_IENCLR, SZ_BYTE, 32'h0000_0100, 1'b0);
    wait_irq(1'b0);
    acc(1'b1, OFS_IENSET, SZ_BYTE, 32'h0001_0000, 1'b0);
    wait_irq(1'b1);
    @(posedge sys_clk);
    wr_protect <= 1'b1;
    // the flag stays clearable under write protection
    acc(1'b1, OFS_IFLAG, SZ_BYTE, 32'h0100_0000, 1'b0);
    wait_irq(1'b0);
    acc(1'b0, OFS_IFLAG, SZ_BYTE, 32'h0, 1'b0);
    chk("flag_clr", 32'h0, rdata);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
